/* File: rtl/ssi_process_input_image.sv */
`timescale 1ns/1ps
`include "ssi_image_cfg.svh"
module ssi_process_input_image #(
   parameter int POS_WIDTH = 32
) (
   input  wire logic                      mclk_i,
   input  wire logic                      sys_rst_i,
   // Output telegram from the gateway
   input  wire logic                      tg_valid_i,
   input  wire ssi_image_pkg::reg_index_t tg_read_index_i,
   input  wire logic                      tg_write_request_i,
   input  wire ssi_image_pkg::reg_index_t tg_write_index_i,
   input  wire ssi_image_pkg::reg_word_t  tg_write_data_i,
   input  wire logic                      clear_compare_a_latch_i,
   input  wire logic                      clear_compare_b_latch_i,
   // Internal register bank, read side
   output logic [5:0]                     regbank_rd_index_o,
   input  wire ssi_image_pkg::reg_word_t  regbank_rd_data_i,
   input  wire logic                      regbank_rd_accept_i,
   // Internal register bank, write side
   output logic                           regbank_wr_strobe_o,
   output logic [5:0]                     regbank_wr_index_o,
   output logic [31:0]                    regbank_wr_data_o,
   input  wire logic                      regbank_wr_done_i,
   input  wire logic                      regbank_wr_ok_i,
   // Encoder and measurement state
   input  wire logic [POS_WIDTH-1:0]      position_i,
   input  wire logic                      position_strobe_i,
   input  wire logic [POS_WIDTH-1:0]      compare_a_i,
   input  wire logic [POS_WIDTH-1:0]      compare_b_i,
   input  wire logic [POS_WIDTH-1:0]      lower_limit_i,
   input  wire logic [POS_WIDTH-1:0]      upper_limit_i,
   input  wire ssi_image_pkg::enc_status_t encoder_status_i,
   input  wire ssi_image_pkg::enc_status_t encoder_status_enable_i,
   input  wire logic                      link_stopped_i,
   input  wire logic                      parameter_error_i,
   input  wire logic                      encoder_signal_fault_i,
   // Process input image towards the gateway
   output logic [63:0]                    image_o,
   output logic                           image_valid_o
);
   import ssi_image_pkg::*;

   compare_if #(.POS_WIDTH(POS_WIDTH)) cmp_a ();
   compare_if #(.POS_WIDTH(POS_WIDTH)) cmp_b ();

   write_state_t        wr_state_q;
   write_state_t        wr_state_d;
   logic                wr_completed_q;
   logic                wr_completed_d;
   logic                wr_strobe_q;
   reg_index_t          wr_index_q;
   reg_word_t           wr_data_q;
   logic                wr_accept;
   logic [POS_WIDTH-1:0] pos_prev_q;
   logic                moving_up_q;
   logic                moving_down_q;
   logic                below_lower;
   logic                above_upper;
   logic                diag_summary;
   reg_word_t           rd_word;
   logic                rd_refused;
   image_byte_t         byte4;
   image_byte_t         byte5;
   image_byte_t         byte6;
   image_byte_t         byte7;
   logic [`IMG_WIDTH-1:0] image_d;
   logic [`IMG_WIDTH-1:0] image_q;
   logic                image_valid_q;
   logic                wr_pending;

   // ==========================================================
   // Shared decodes
   // One ordering helper keeps direction and limit tests unsigned alike
   function automatic logic pos_below(input logic [POS_WIDTH-1:0] lhs,
                                      input logic [POS_WIDTH-1:0] rhs);
      return (lhs < rhs);
   endfunction

   // Busy decode, used for the accept gate and the pending bit
   function automatic logic wr_busy(input write_state_t state);
      return (state == WR_BUSY);
   endfunction

   // ==========================================================
   // Compare units
   assign cmp_a.position      = position_i;
   assign cmp_a.compare_value = compare_a_i;
   assign cmp_a.clear         = tg_valid_i & clear_compare_a_latch_i;
   assign cmp_b.position      = position_i;
   assign cmp_b.compare_value = compare_b_i;
   assign cmp_b.clear         = tg_valid_i & clear_compare_b_latch_i;

   compare_latch_unit u_cmp_a (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .cmp       (cmp_a)
   );

   compare_latch_unit u_cmp_b (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .cmp       (cmp_b)
   );

   // ==========================================================
   // Read path: bank answers combinationally in the telegram cycle
   // Refusal zeroes the word here, so a stale bank value never leaks
   assign regbank_rd_index_o = tg_read_index_i;
   assign rd_refused         = ~regbank_rd_accept_i;
   assign rd_word            = rd_refused ? `WORD_RESET : regbank_rd_data_i;

   // ==========================================================
   // Write handshake
   // A request while busy is dropped, not queued: the pending bit
   // tells the controller to retry later
   assign wr_accept = tg_valid_i & tg_write_request_i & ~wr_busy(wr_state_q);

   always_comb begin
      wr_state_d     = wr_state_q;
      wr_completed_d = wr_completed_q;
      case (wr_state_q)
         WR_IDLE: begin
            if (wr_accept) begin
               wr_state_d = WR_BUSY;
            end
         end
         WR_BUSY: begin
            if (regbank_wr_done_i) begin
               wr_state_d     = WR_IDLE;
               wr_completed_d = regbank_wr_ok_i;
            end
         end
         default: begin
            wr_state_d = WR_IDLE;
         end
      endcase
   end

   // Write state registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wr_state_q     <= WR_IDLE;
         wr_completed_q <= 1'b0;
         wr_strobe_q    <= 1'b0;
      end else begin
         wr_state_q     <= wr_state_d;
         wr_completed_q <= wr_completed_d;
         wr_strobe_q    <= wr_accept;
      end
   end

   // Write job capture, held stable while busy
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wr_index_q <= '0;
         wr_data_q  <= `WORD_RESET;
      end else if (wr_accept) begin
         wr_index_q <= tg_write_index_i;
         wr_data_q  <= tg_write_data_i;
      end
   end

   assign regbank_wr_strobe_o = wr_strobe_q;
   assign regbank_wr_index_o  = wr_index_q;
   assign regbank_wr_data_o   = wr_data_q;

   // ==========================================================
   // Direction of movement from successive position samples
   // An unchanged sample clears both, so a stopped axis shows neither
   // A wrap of the encoder count reads as a jump the other way
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pos_prev_q    <= '0;
         moving_up_q   <= 1'b0;
         moving_down_q <= 1'b0;
      end else if (position_strobe_i) begin
         pos_prev_q    <= position_i;
         moving_up_q   <= pos_below(pos_prev_q, position_i);
         moving_down_q <= pos_below(position_i, pos_prev_q);
      end
   end

   // ==========================================================
   // Live limit and diagnostic status
   assign below_lower  = pos_below(position_i, lower_limit_i);
   assign above_upper  = pos_below(upper_limit_i, position_i);
   assign diag_summary = |(encoder_status_i & encoder_status_enable_i);

   // ==========================================================
   // Image bytes 4 to 7
   // Pending shows the next state, so an accepting telegram already reports it
   assign wr_pending = wr_busy(wr_state_d);
   assign byte4 = {rd_refused, 1'b0, tg_read_index_i};
   assign byte5 = {wr_completed_d, wr_pending, 2'b00,
                   encoder_status_i};
   assign byte6 = {moving_up_q, moving_down_q,
                   cmp_b.at_or_above, cmp_b.match_latch, cmp_b.equal,
                   cmp_a.at_or_above, cmp_a.match_latch, cmp_a.equal};
   assign byte7 = {link_stopped_i, 2'b00, parameter_error_i, below_lower,
                   above_upper, encoder_signal_fault_i, diag_summary};

   // Byte 0 sits in the top lane, so the word goes out MSB first
   assign image_d = {rd_word, byte4, byte5, byte6, byte7};

   // ==========================================================
   // Response image, refreshed once per telegram
   // Between telegrams the image holds; only the valid pulse marks news
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         image_q       <= `IMG_RESET;
         image_valid_q <= 1'b0;
      end else begin
         image_valid_q <= tg_valid_i;
         if (tg_valid_i) begin
            image_q <= image_d;
         end
      end
   end

   assign image_o       = image_q;
   assign image_valid_o = image_valid_q;
endmodule

/* File: rtl/ssi_image_cfg.svh */
`ifndef SSI_IMAGE_CFG_SVH
`define SSI_IMAGE_CFG_SVH

// ==========================================================
// Widths
`define IMG_BYTES        8
`define IMG_WIDTH        64
`define REG_DATA_WIDTH   32
`define REG_INDEX_WIDTH  6
`define ENC_STS_WIDTH    4

// ==========================================================
// Byte 4 fields
`define B4_RD_REFUSED    7
`define B4_RESERVED      6
// Byte 5 fields
`define B5_WR_COMPLETED  7
`define B5_WR_PENDING    6
// Byte 6 fields
`define B6_MOVING_UP     7
`define B6_MOVING_DOWN   6
`define B6_GE_CMP_B      5
`define B6_LATCH_CMP_B   4
`define B6_EQ_CMP_B      3
`define B6_GE_CMP_A      2
`define B6_LATCH_CMP_A   1
`define B6_EQ_CMP_A      0
// Byte 7 fields
`define B7_LINK_STOPPED  7
`define B7_PARAM_ERROR   4
`define B7_BELOW_LOWER   3
`define B7_ABOVE_UPPER   2
`define B7_SIGNAL_FAULT  1
`define B7_DIAG_SUMMARY  0

// ==========================================================
// Reset values
`define IMG_RESET        64'h0000_0000_0000_0000
`define WORD_RESET       32'h0000_0000
`endif

/* File: rtl/ssi_image_pkg.sv */
package ssi_image_pkg;
`include "ssi_image_cfg.svh"
   typedef logic [`REG_INDEX_WIDTH-1:0] reg_index_t;
   typedef logic [`REG_DATA_WIDTH-1:0]  reg_word_t;
   typedef logic [7:0]                  image_byte_t;
   typedef logic [`ENC_STS_WIDTH-1:0]   enc_status_t;
   // Write handshake states
   typedef enum logic [0:0] {
      WR_IDLE = 1'b0,
      WR_BUSY = 1'b1
   } write_state_t;
endpackage

/* File: rtl/compare_if.sv */
`timescale 1ns/1ps
interface compare_if #(parameter int POS_WIDTH = 32);
   logic [POS_WIDTH-1:0] position;
   logic [POS_WIDTH-1:0] compare_value;
   logic                 clear;
   logic                 equal;
   logic                 at_or_above;
   logic                 match_latch;
   modport unit  (input position, compare_value, clear, output equal, at_or_above, match_latch);
   modport owner (output position, compare_value, clear, input equal, at_or_above, match_latch);
endinterface

/* File: rtl/compare_latch_unit.sv */
`timescale 1ns/1ps
module compare_latch_unit (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   compare_if.unit  cmp
);
   import ssi_image_pkg::*;

   logic hit;
   logic equal_q;
   logic at_or_above_q;
   logic latch_q;

   // ==========================================================
   // Comparison
   assign hit = (cmp.position == cmp.compare_value);

   // Live results follow the position; the latch holds a match
   // until cleared, and a match in the clear cycle wins
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         equal_q       <= 1'b0;
         at_or_above_q <= 1'b0;
         latch_q       <= 1'b0;
      end else begin
         equal_q       <= hit;
         at_or_above_q <= (cmp.position >= cmp.compare_value);
         if (hit) begin
            latch_q <= 1'b1;
         end else if (cmp.clear) begin
            latch_q <= 1'b0;
         end
      end
   end

   assign cmp.equal       = equal_q;
   assign cmp.at_or_above = at_or_above_q;
   assign cmp.match_latch = latch_q;
endmodule

/* File: dv/regbank_model.sv */
`timescale 1ns/1ps
// ==============================
// Register bank stand-in
module regbank_model (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [5:0]  rd_index_i,
   output logic [31:0]      rd_data_o,
   output logic             rd_accept_o,
   input  wire logic        wr_strobe_i,
   input  wire logic [5:0]  wr_index_i,
   input  wire logic [31:0] wr_data_i,
   output logic             wr_done_o,
   output logic             wr_ok_o
);
   logic [31:0] mem_q [64];
   int          cnt_q;
   // Top four indices refuse; the word is then garbage so zeroing shows
   assign rd_accept_o = rd_index_i < 6'd60;
   assign rd_data_o   = rd_accept_o ? mem_q[rd_index_i] : ~mem_q[rd_index_i];
   // Slow write, done six cycles on; index 0 is read-only, ok toggles outside done
   always_ff @(posedge mclk_i) begin
      wr_done_o <= 1'b0;
      wr_ok_o   <= ~wr_ok_o;
      if (sys_rst_i) begin
         cnt_q   <= 0;
         wr_ok_o <= 1'b0;
         for (int i = 0; i < 64; i++) mem_q[i] <= 32'h1357_9bdf * i;
      end else if (wr_strobe_i) begin
         cnt_q <= 6;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
         if (cnt_q == 1) begin
            wr_done_o <= 1'b1;
            wr_ok_o   <= wr_index_i != 6'h00;
            if (wr_index_i != 6'h00) mem_q[wr_index_i] <= wr_data_i;
         end
      end
   end
endmodule

/* File: dv/ssi_process_input_image_sva.sv */
`timescale 1ns/1ps
// ==============================
// Image protocol checker
module ssi_image_checker (
   input wire logic                      mclk_i,
   input wire logic                      sys_rst_i,
   input wire logic                      tg_valid_i,
   input wire ssi_image_pkg::reg_index_t tg_read_index_i,
   input wire logic                      tg_write_request_i,
   input wire ssi_image_pkg::reg_index_t tg_write_index_i,
   input wire ssi_image_pkg::reg_word_t  tg_write_data_i,
   input wire ssi_image_pkg::reg_word_t  regbank_rd_data_i,
   input wire logic                      regbank_rd_accept_i,
   input wire logic                      regbank_wr_strobe_o,
   input wire logic [5:0]                regbank_wr_index_o,
   input wire logic [31:0]               regbank_wr_data_o,
   input wire logic                      regbank_wr_done_i,
   input wire logic                      regbank_wr_ok_i,
   input wire logic [63:0]               image_o,
   input wire logic                      image_valid_o
);
   import ssi_image_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Telegram steps
   sequence s_read(logic acc);
      tg_valid_i && regbank_rd_accept_i == acc;
   endsequence
   sequence s_wr_end;
      tg_valid_i && regbank_wr_done_i;
   endsequence
   a_answer_pulse: assert property (tg_valid_i |=> image_valid_o && image_o[29:24] == $past(tg_read_index_i))
      else $error("answer or index echo wrong");
   a_idle_quiet: assert property (!tg_valid_i |=> !image_valid_o && $stable(image_o))
      else $error("image moved without telegram");
   a_read_ok: assert property (s_read(1'b1) |=> image_o[63:31] == {$past(regbank_rd_data_i), 1'b0})
      else $error("read word wrong");
   a_read_refused: assert property (s_read(1'b0) |=> image_o[63:31] == 33'h1)
      else $error("refused read not zeroed");
   a_wr_result: assert property (s_wr_end |=> image_o[23:22] == {$past(regbank_wr_ok_i), 1'b0})
      else $error("write result wrong");
   a_pending_shown: assert property (regbank_wr_strobe_o |-> image_valid_o && image_o[22])
      else $error("pending not shown");
   a_strobe_cause: assert property (regbank_wr_strobe_o |-> $past(tg_valid_i && tg_write_request_i)
      && regbank_wr_index_o == $past(tg_write_index_i) && regbank_wr_data_o == $past(tg_write_data_i))
      else $error("write job wrong");
   a_reserved_zero: assert property (image_valid_o |-> {image_o[30], image_o[21:20], image_o[6:5]} == 5'h00)
      else $error("reserved bit set");
endmodule

bind ssi_process_input_image ssi_image_checker i_ssi_image_checker (.mclk_i, .sys_rst_i, .tg_valid_i,
   .tg_read_index_i, .tg_write_request_i, .tg_write_index_i, .tg_write_data_i, .regbank_rd_data_i,
   .regbank_rd_accept_i, .regbank_wr_strobe_o, .regbank_wr_index_o, .regbank_wr_data_o, .regbank_wr_done_i,
   .regbank_wr_ok_i, .image_o, .image_valid_o);

/* File: dv/tb_ssi_process_input_image.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_ssi_process_input_image;
   import ssi_image_pkg::*;
   logic        mclk_i, sys_rst_i, position_strobe_i, regbank_rd_accept_i, regbank_wr_done_i, regbank_wr_ok_i;
   logic        tg_valid_i, tg_write_request_i, clear_compare_a_latch_i, clear_compare_b_latch_i, image_valid_o;
   logic        regbank_wr_strobe_o, link_stopped_i, parameter_error_i, encoder_signal_fault_i;
   reg_index_t  tg_read_index_i, tg_write_index_i;
   reg_word_t   tg_write_data_i, regbank_rd_data_i;
   logic [5:0]  regbank_rd_index_o, regbank_wr_index_o;
   logic [31:0] regbank_wr_data_o, position_i, compare_a_i, compare_b_i, lower_limit_i, upper_limit_i;
   enc_status_t encoder_status_i, encoder_status_enable_i;
   logic [63:0] image_o;
   logic [47:0] tgv = '0;
   logic [74:0] stv = '0;
   logic [31:0] exp_mem [64];
   logic [31:0] prv = '0, wd_q;
   logic [5:0]  wi_q;
   logic        pend = 1'b0, comp = 1'b0, up = 1'b0, down = 1'b0, la = 1'b0, lb = 1'b0;
   int          error_cnt = 0, n_compared = 0, stb_cnt = 0, exp_stb = 0;
   // Packed so one assignment drives a whole telegram
   assign {tg_valid_i, tg_read_index_i, tg_write_request_i, tg_write_index_i, tg_write_data_i,
           clear_compare_a_latch_i, clear_compare_b_latch_i} = tgv;
   assign {encoder_status_i, encoder_status_enable_i, link_stopped_i, parameter_error_i,
           encoder_signal_fault_i, lower_limit_i, upper_limit_i} = stv;
   assign compare_a_i = 32'h64;
   assign compare_b_i = 32'hc8;
   ssi_process_input_image i_ssi_process_input_image (.*);
   regbank_model i_regbank_model (.mclk_i, .sys_rst_i, .rd_index_i(regbank_rd_index_o), .rd_data_o(regbank_rd_data_i),
      .rd_accept_o(regbank_rd_accept_i), .wr_strobe_i(regbank_wr_strobe_o), .wr_index_i(regbank_wr_index_o),
      .wr_data_i(regbank_wr_data_o), .wr_done_o(regbank_wr_done_i), .wr_ok_o(regbank_wr_ok_i));
   // ==============================
   // Clock and strobe count
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   // A write that ends between telegrams is retired here
   always @(posedge mclk_i) begin
      if (regbank_wr_strobe_o === 1'b1) stb_cnt++;
      if (pend && regbank_wr_done_i === 1'b1) absorb();
   end
   // ==============================
   // Tasks
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // End of the pending write: completion follows the bank's verdict
   task automatic absorb();
      pend = 1'b0;
      comp = wi_q != 6'h00;
      if (comp) exp_mem[wi_q] = wd_q;
   endtask
   // One telegram; a clearing telegram still shows the latch as it stood, and a live match wins
   task automatic tg(input logic [5:0] ri, input logic wq, input logic [5:0] wi, input logic [31:0] wd,
                     input logic ca, input logic cb);
      logic [63:0] e;
      logic        acc;
      @(posedge mclk_i);
      tgv <= {1'b1, ri, wq, wi, wd, ca, cb};
      #1;
      acc = wq && !pend;
      // A write ending in this telegram's own cycle already reads as done
      if (pend && regbank_wr_done_i === 1'b1) absorb();
      if (acc) begin
         pend = 1'b1;
         wi_q = wi;
         wd_q = wd;
         exp_stb++;
      end
      e = {ri < 6'd60 ? exp_mem[ri] : 32'h0, ri >= 6'd60, 1'b0, ri, comp, pend, 2'b00, encoder_status_i,
           up, down, position_i >= compare_b_i, lb, position_i == compare_b_i, position_i >= compare_a_i, la,
           position_i == compare_a_i, link_stopped_i, 2'b00, parameter_error_i, position_i < lower_limit_i,
           position_i > upper_limit_i, encoder_signal_fault_i, |(encoder_status_i & encoder_status_enable_i)};
      la = (la && !ca) || position_i == compare_a_i;
      lb = (lb && !cb) || position_i == compare_b_i;
      @(posedge mclk_i);
      tgv <= '0;
      #1;
      `CHK(image_valid_o, 1'b1)
      `CHK(image_o, e)
   endtask
   // Bounded wait until the pending write has been retired
   task automatic wdone();
      int n;
      for (n = 0; n < 20 && pend; n++) begin
         @(posedge mclk_i);
         #1;
      end
      if (pend) begin
         error_cnt++;
         finish_test();
      end
   endtask
   // Move the encoder, let the registered flags settle, then ask for an image
   task automatic mt(input logic [31:0] p, input logic ca, input logic cb);
      @(posedge mclk_i);
      position_i <= p;
      position_strobe_i <= 1'b1;
      @(posedge mclk_i);
      position_strobe_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      up = p > prv;
      down = p < prv;
      prv = p;
      la = la | (p == compare_a_i);
      lb = lb | (p == compare_b_i);
      tg(6'h03, 1'b0, 6'h00, 32'h0, ca, cb);
   endtask
   // ==============================
   // Main sequence
   initial begin
      logic [31:0] d;
      void'($urandom(32'he126a75a));
      sys_rst_i = 1'b1;
      position_i = '0;
      position_strobe_i = 1'b0;
      for (int i = 0; i < 64; i++) exp_mem[i] = 32'h1357_9bdf * i;
      repeat (5) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 14; i++) tg(i < 2 ? 6'(62 - i * 3) : 6'($urandom), 1'b0, 6'h00, 32'h0, 1'b0, 1'b0);
      $display("test reads end");
      d = $urandom;
      tg(6'h2a, 1'b1, 6'h2a, d, 1'b0, 1'b0);
      // Dropped while pending; the last one meets the bank's done cycle
      repeat (4) tg(6'h2a, 1'b1, 6'h2a, ~d, 1'b0, 1'b0);
      tg(6'h2a, 1'b1, 6'h00, d, 1'b0, 1'b0);
      wdone();
      tg(6'h00, 1'b0, 6'h00, 32'h0, 1'b0, 1'b0);
      `CHK(stb_cnt, exp_stb)
      $display("test writes end");
      mt(32'h64, 1'b0, 1'b0);
      mt(32'h96, 1'b0, 1'b0);
      mt(32'hc8, 1'b1, 1'b0);
      mt(32'hc8, 1'b0, 1'b0);
      mt(32'h32, 1'b0, 1'b1);
      mt(32'h32, 1'b0, 1'b0);
      // Clear meeting a live match: the match wins
      mt(32'h64, 1'b1, 1'b0);
      $display("test compares end");
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk_i);
         stv <= {11'($urandom), $urandom % 128, $urandom % 128};
         tg(6'($urandom), 1'b0, 6'h00, 32'h0, 1'b0, 1'b0);
      end
      $display("test status end");
      finish_test();
   end
endmodule
